// >>> pkg/vaclt_pkg.sv
// package: constants, types and field layouts of the valve actuator control
//------------------------------------------------------------------------------
// Function
// - both-torque mode: limits only arm the stop
// - torque stops motor; restart only reverse direction
// - torque flags use direction before stop
// - torque must clear 0.5 s after start
// - power-up torque without limits: closing fault
// - closed-torque mode: open limit stops, close only
// - closed limit arms; torque stops; unarmed faults
// - open-torque mode: closed limit stops, open only
// - armed torque stops; unarmed or closing faults
// - limits active high; torque active when low
// - run-time supervision; limit of 1 s disables
// - departed limit must release within start time
// - mid-travel torque faults; reset; reverse only
// - reset and reverse start repeatable without limit
// - spare outputs follow command bits 15 and 12 unless set as fault output
//------------------------------------------------------------------------------
package vaclt_pkg;

  // register offsets, word index on the fieldbus exchange
  localparam logic [3:0] VACLT_STATUS_WORD_OFS = 4'h0;
  localparam logic [3:0] VACLT_COMMAND_WORD_OFS = 4'h0;
  localparam logic [3:0] VACLT_CURRENT_WORD_OFS = 4'h1;
  localparam logic [15:0] VACLT_WORD_RESET = 16'h0000;

  // command word field positions
  localparam int VACLT_CMD_CLOSE = 0;
  localparam int VACLT_CMD_OFF = 1;
  localparam int VACLT_CMD_OPEN = 2;
  localparam int VACLT_CMD_FAULT_RESET = 6;
  localparam int VACLT_CMD_SUPPLY = 12;
  localparam int VACLT_CMD_RELAY = 15;

  // status word field positions
  localparam int VACLT_STS_CLOSING = 0;
  localparam int VACLT_STS_OFF = 1;
  localparam int VACLT_STS_OPENING = 2;
  localparam int VACLT_STS_FAULT = 6;
  localparam int VACLT_STS_WARNING = 7;
  localparam int VACLT_STS_DI_LSB = 10;

  // timing, in ms, and the control tick rate
  localparam longint VACLT_CLK_HZ = 40000000;
  localparam int VACLT_TICK_MS = 1;
  localparam int VACLT_TICK_CYCLES = int'((VACLT_CLK_HZ * VACLT_TICK_MS) / 1000);
  localparam int VACLT_TORQUE_CLEAR_MS = 500;
  localparam int VACLT_START_MON_MS = 3000;
  localparam int VACLT_RUN_LIMIT_MS = 30000;
  localparam int VACLT_RUN_DISABLE_MS = 1000;

  // switch arrangement
  typedef enum logic [1:0] {
    VACLT_MODE_BOTH_TORQUE,
    VACLT_MODE_CLOSED_TORQUE,
    VACLT_MODE_OPEN_TORQUE
  } vaclt_mode_t;

  typedef enum logic [1:0] {
    VACLT_DIR_NONE,
    VACLT_DIR_OPEN,
    VACLT_DIR_CLOSE
  } vaclt_dir_t;

endpackage : vaclt_pkg

// >>> pkg/vaclt_tick_if.sv
// interface: control tick pulse between the divider and the control logic
`timescale 1ns/100ps
interface vaclt_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface : vaclt_tick_if

// >>> hw/vaclt_tick.sv
// divider making the one-cycle control tick enable
`timescale 1ns/100ps
module vaclt_tick
  import vaclt_pkg::*;
#(
  parameter int DIVIDE = VACLT_TICK_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // tick out
  vaclt_tick_if.src tk
);

  typedef struct packed {
    logic [31:0] count;
    logic tick;
  } vaclt_tick_state_t;

  vaclt_tick_state_t st;
  vaclt_tick_state_t next_st;

  // count up to one enable per period
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.count >= 32'(DIVIDE - 1)) begin
      next_st.count = 32'h0;
      next_st.tick = 1'b1;
    end else begin
      next_st.count = st.count + 32'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tk.tick = st.tick;

endmodule : vaclt_tick

// >>> hw/vaclt_control.sv
// valve actuator limit and torque control, top module
`timescale 1ns/100ps
module vaclt_control
  import vaclt_pkg::*;
#(
  parameter int TICK_DIVIDE = VACLT_TICK_CYCLES,
  parameter int TORQUE_CLEAR_MS = VACLT_TORQUE_CLEAR_MS,
  parameter int START_MON_MS = VACLT_START_MON_MS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // configuration
  input wire vaclt_mode_t mode,
  input wire logic [15:0] run_limit_ms,
  input wire logic relay_is_fault_output,
  input wire logic supply_is_fault_output,
  // switch inputs
  input wire logic open_limit_input,
  input wire logic closed_limit_input,
  input wire logic spare_fault_input,
  input wire logic combined_torque_input,
  input wire logic [1:0] extra_inputs,
  // fieldbus words
  input wire logic [15:0] actuator_command_word,
  input wire logic command_word_valid,
  input wire logic [15:0] motor_current_percent_in,
  output logic [15:0] actuator_status_word,
  output logic [15:0] motor_current_percent,
  // motor and spare outputs
  output logic motor_open,
  output logic motor_close,
  output logic spare_relay_output,
  output logic switched_supply_output,
  output logic torque_open_flag,
  output logic torque_closed_flag
);

  //----------------------------------------------------------------------------
  // state
  //----------------------------------------------------------------------------
  typedef struct packed {
    vaclt_dir_t run;
    vaclt_dir_t last_dir;
    vaclt_dir_t blocked;
    logic arm_open;
    logic arm_close;
    logic fault;
    logic warning;
    logic torque_check;
    logic [15:0] torque_ms;
    logic start_check;
    logic start_from_open;
    logic [15:0] start_ms;
    logic [15:0] run_ms;
    logic powered;
    logic tq_open;
    logic tq_closed;
    logic [15:0] status;
    logic [15:0] current;
    logic relay;
    logic supply;
  } vaclt_state_t;

  vaclt_state_t st;
  vaclt_state_t next_st;
  // tick enable from the divider
  vaclt_tick_if tk_if ();

  // torque level and qualified command strobes
  logic torque;
  logic cmd_open;
  logic cmd_close;
  logic cmd_off;
  logic cmd_reset;

  //----------------------------------------------------------------------------
  // tick divider
  //----------------------------------------------------------------------------
  // control tick divider
  vaclt_tick #(
    .DIVIDE(TICK_DIVIDE)
  ) u_tick (
    .ref_clk(ref_clk),
    .srst(srst),
    .tk(tk_if.src)
  );

  //----------------------------------------------------------------------------
  // command decode
  //----------------------------------------------------------------------------
  // torque loop is normally closed, so a low level is active
  assign torque = ~combined_torque_input;
  assign cmd_off = command_word_valid & actuator_command_word[VACLT_CMD_OFF];
  assign cmd_open = command_word_valid & actuator_command_word[VACLT_CMD_OPEN];
  assign cmd_close = command_word_valid & actuator_command_word[VACLT_CMD_CLOSE];
  assign cmd_reset = command_word_valid & actuator_command_word[VACLT_CMD_FAULT_RESET];

  //----------------------------------------------------------------------------
  // helper functions
  //----------------------------------------------------------------------------
  // saturating millisecond count, never wraps back to zero
  function automatic logic [15:0] vaclt_inc(input logic [15:0] v);
    vaclt_inc = (v == 16'hffff) ? v : v + 16'h1;
  endfunction : vaclt_inc

  // stop the motor, remember the direction it had, block that direction when block is set
  function automatic vaclt_state_t vaclt_halt(input vaclt_state_t s, input logic block);
    vaclt_state_t r;
    r = s;
    if (s.run != VACLT_DIR_NONE) begin
      r.last_dir = s.run;
    end
    // a stop while idle blocks the direction of the last run
    if (block) begin
      r.blocked = (s.run != VACLT_DIR_NONE) ? s.run : s.last_dir;
    end
    r.run = VACLT_DIR_NONE;
    r.arm_open = 1'b0;
    r.arm_close = 1'b0;
    r.start_check = 1'b0;
    return r;
  endfunction : vaclt_halt

  //----------------------------------------------------------------------------
  // control logic
  //----------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    // power-up torque with no limit present: assume closing
    if (!st.powered) begin
      // run, stop and fault reset commands are not acted on in this first cycle
      next_st.powered = 1'b1;
      if (torque && !open_limit_input && !closed_limit_input) begin
        next_st.fault = 1'b1;
        next_st.last_dir = VACLT_DIR_CLOSE;
        next_st.blocked = VACLT_DIR_CLOSE;
      end
    end else begin
      // fault reset, then starts; repeatable without count
      if (cmd_reset) begin
        next_st.fault = 1'b0;
      end
      // stop has precedence over either run command
      if (cmd_off) begin
        next_st = vaclt_halt(next_st, 1'b0);
      end else if (!next_st.fault && st.run == VACLT_DIR_NONE) begin
        if (cmd_open && !cmd_close && st.blocked != VACLT_DIR_OPEN) begin
          next_st.run = VACLT_DIR_OPEN;
          next_st.blocked = VACLT_DIR_NONE;
          next_st.start_check = closed_limit_input;
          next_st.start_from_open = 1'b0;
          // arms left over from a cut run must not skip the torque fault
          next_st.arm_open = 1'b0;
          next_st.arm_close = 1'b0;
          next_st.start_ms = 16'h0;
          next_st.run_ms = 16'h0;
          next_st.torque_check = torque;
          next_st.torque_ms = 16'h0;
        end else if (cmd_close && !cmd_open && st.blocked != VACLT_DIR_CLOSE) begin
          next_st.run = VACLT_DIR_CLOSE;
          next_st.blocked = VACLT_DIR_NONE;
          next_st.start_check = open_limit_input;
          next_st.start_from_open = 1'b1;
          next_st.arm_open = 1'b0;
          next_st.arm_close = 1'b0;
          next_st.start_ms = 16'h0;
          next_st.run_ms = 16'h0;
          next_st.torque_check = torque;
          next_st.torque_ms = 16'h0;
        end
      end

      // limit switches while running
      if (st.run == VACLT_DIR_OPEN && open_limit_input) begin
        if (mode == VACLT_MODE_CLOSED_TORQUE) begin
          next_st = vaclt_halt(next_st, 1'b1);
        end else begin
          next_st.arm_open = 1'b1;
        end
      end
      if (st.run == VACLT_DIR_CLOSE && closed_limit_input) begin
        if (mode == VACLT_MODE_OPEN_TORQUE) begin
          next_st = vaclt_halt(next_st, 1'b1);
        end else begin
          next_st.arm_close = 1'b1;
        end
      end

      // torque while running, past the start clearance window
      if (st.run != VACLT_DIR_NONE && torque && !st.torque_check) begin
        // an armed stop is normal; any other torque is a fault
        unique case (mode)
          VACLT_MODE_BOTH_TORQUE: begin
            if (!(st.arm_open || st.arm_close)) begin
              next_st.fault = 1'b1;
            end
          end
          VACLT_MODE_CLOSED_TORQUE: begin
            if (!(st.run == VACLT_DIR_CLOSE && st.arm_close)) begin
              next_st.fault = 1'b1;
            end
          end
          VACLT_MODE_OPEN_TORQUE: begin
            if (!(st.run == VACLT_DIR_OPEN && st.arm_open)) begin
              next_st.fault = 1'b1;
            end
          end
          default: begin
            next_st.fault = 1'b1;
          end
        endcase
        // every torque stop blocks the direction it ran in
        next_st = vaclt_halt(next_st, 1'b1);
      end

      // millisecond supervision timers
      if (tk_if.tick && st.run != VACLT_DIR_NONE) begin
        // start into a held torque: it must clear within the window
        if (st.torque_check) begin
          next_st.torque_ms = vaclt_inc(st.torque_ms);
          if (!torque) begin
            next_st.torque_check = 1'b0;
          end else if (st.torque_ms >= 16'(TORQUE_CLEAR_MS - 1)) begin
            next_st.fault = 1'b1;
            next_st = vaclt_halt(next_st, 1'b1);
          end
        end
        // the departed end limit must open within the start window
        if (st.start_check) begin
          next_st.start_ms = vaclt_inc(st.start_ms);
          if (!(st.start_from_open ? open_limit_input : closed_limit_input)) begin
            next_st.start_check = 1'b0;
          end else if (st.start_ms >= 16'(START_MON_MS - 1)) begin
            next_st.fault = 1'b1;
            next_st = vaclt_halt(next_st, 1'b0);
          end
        end
        // run-time check; the disable value switches it off
        next_st.run_ms = vaclt_inc(st.run_ms);
        if (run_limit_ms != 16'(VACLT_RUN_DISABLE_MS) && st.run_ms >= run_limit_ms) begin
          next_st.fault = 1'b1;
          next_st = vaclt_halt(next_st, 1'b0);
        end
      end

      // split torque by the direction held before the stop
      next_st.tq_open = torque && (next_st.last_dir == VACLT_DIR_OPEN);
      next_st.tq_closed = torque && (next_st.last_dir == VACLT_DIR_CLOSE);
    end

    // warning: torque seen with motor stopped and no fault latched
    next_st.warning = torque && !next_st.fault && next_st.run == VACLT_DIR_NONE;

    // status word refreshed every cycle
    next_st.status = VACLT_WORD_RESET;
    next_st.status[VACLT_STS_CLOSING] = next_st.run == VACLT_DIR_CLOSE;
    next_st.status[VACLT_STS_OFF] = next_st.run == VACLT_DIR_NONE;
    next_st.status[VACLT_STS_OPENING] = next_st.run == VACLT_DIR_OPEN;
    next_st.status[VACLT_STS_FAULT] = next_st.fault;
    next_st.status[VACLT_STS_WARNING] = next_st.warning;
    next_st.status[VACLT_STS_DI_LSB +: 6] = {extra_inputs, combined_torque_input,
                                             spare_fault_input, closed_limit_input,
                                             open_limit_input};
    next_st.current = motor_current_percent_in;

    // spare outputs follow the command unless they serve as fault output
    if (command_word_valid) begin
      next_st.relay = actuator_command_word[VACLT_CMD_RELAY];
      next_st.supply = actuator_command_word[VACLT_CMD_SUPPLY];
    end
    if (relay_is_fault_output) begin
      next_st.relay = next_st.fault;
    end
    if (supply_is_fault_output) begin
      next_st.supply = next_st.fault;
    end
  end

  //----------------------------------------------------------------------------
  // state register
  //----------------------------------------------------------------------------
  // single state register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  //----------------------------------------------------------------------------
  // outputs
  //----------------------------------------------------------------------------
  // one encoded direction cannot drive both contactors at once
  assign motor_open = st.run == VACLT_DIR_OPEN;
  assign motor_close = st.run == VACLT_DIR_CLOSE;
  // data outputs straight from the state flip-flops
  assign actuator_status_word = st.status;
  assign motor_current_percent = st.current;
  assign spare_relay_output = st.relay;
  assign switched_supply_output = st.supply;
  assign torque_open_flag = st.tq_open;
  assign torque_closed_flag = st.tq_closed;

endmodule : vaclt_control

// >>> testbench/vaclt_properties.sv
// checker: concurrent properties on the valve actuator control ports
`timescale 1ns/100ps
module vaclt_control_checker
  import vaclt_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // inputs watched
  input wire vaclt_mode_t mode,
  input wire logic relay_is_fault_output,
  input wire logic supply_is_fault_output,
  input wire logic open_limit_input,
  input wire logic closed_limit_input,
  input wire logic combined_torque_input,
  input wire logic [15:0] actuator_command_word,
  input wire logic command_word_valid,
  // outputs watched
  input wire logic [15:0] actuator_status_word,
  input wire logic motor_open,
  input wire logic motor_close,
  input wire logic spare_relay_output,
  input wire logic switched_supply_output,
  input wire logic torque_open_flag,
  input wire logic torque_closed_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  //----------------------------------------
  // properties
  //----------------------------------------
  one_motor_a: assert property (!(motor_open && motor_close))
    else $error("both motor outputs on");
  status_dir_a: assert property (actuator_status_word[2:0] != 3'b111 &&
    actuator_status_word[VACLT_STS_OPENING] == motor_open &&
    actuator_status_word[VACLT_STS_CLOSING] == motor_close) else $error("status dir bits wrong");
  limit_mirror_a: assert property (1'b1 |=> actuator_status_word[11:10] ==
    $past({closed_limit_input, open_limit_input})) else $error("limit mirror wrong");
  torque_raw_a: assert property (1'b1 |=>
    actuator_status_word[13] == $past(combined_torque_input)) else $error("torque mirror wrong");
  torque_flags_a: assert property ((torque_open_flag || torque_closed_flag) |->
    !$past(combined_torque_input) && !(torque_open_flag && torque_closed_flag))
    else $error("torque flag without torque");
  block_open_a: assert property (torque_open_flag && !motor_open |=> !motor_open)
    else $error("open started after open torque");
  block_close_a: assert property (torque_closed_flag && !motor_close |=> !motor_close)
    else $error("close started after closed torque");
  open_stop_a: assert property (mode == VACLT_MODE_CLOSED_TORQUE && motor_open &&
    open_limit_input |=> !motor_open) else $error("open limit did not stop");
  close_stop_a: assert property (mode == VACLT_MODE_OPEN_TORQUE && motor_close &&
    closed_limit_input |=> !motor_close) else $error("closed limit did not stop");
  relay_follow_a: assert property (command_word_valid && !relay_is_fault_output |=>
    spare_relay_output == $past(actuator_command_word[VACLT_CMD_RELAY]))
    else $error("relay not following command");
  supply_follow_a: assert property (command_word_valid && !supply_is_fault_output |=>
    switched_supply_output == $past(actuator_command_word[VACLT_CMD_SUPPLY]))
    else $error("supply not following command");
  relay_fault_a: assert property (relay_is_fault_output |=>
    spare_relay_output == actuator_status_word[VACLT_STS_FAULT])
    else $error("relay not showing fault");
  supply_fault_a: assert property (supply_is_fault_output |=>
    switched_supply_output == actuator_status_word[VACLT_STS_FAULT])
    else $error("supply not showing fault");
  // main scenarios reached
  cov_open: cover property ($rose(motor_open));
  cov_tflag: cover property ($rose(torque_open_flag));
  cov_fault: cover property ($rose(actuator_status_word[VACLT_STS_FAULT]));
endmodule : vaclt_control_checker

bind vaclt_control vaclt_control_checker u_chk (.ref_clk, .srst, .mode,
  .relay_is_fault_output, .supply_is_fault_output, .open_limit_input,
  .closed_limit_input, .combined_torque_input, .actuator_command_word,
  .command_word_valid, .actuator_status_word, .motor_open, .motor_close,
  .spare_relay_output, .switched_supply_output, .torque_open_flag, .torque_closed_flag);

// >>> testbench/vaclt_switch_model.sv
// partner model: valve travel with end limit and torque contacts
`timescale 1ns/100ps
module vaclt_switch_model #(
  parameter int TRAVEL = 200,
  parameter int START_POS = 100
) (
  // clock and motor drive
  input wire logic ref_clk,
  input wire logic motor_open,
  input wire logic motor_close,
  // jammed valve trips torque
  input wire logic jam,
  // switch contacts
  output logic open_limit_input,
  output logic closed_limit_input,
  output logic spare_fault_input,
  output logic combined_torque_input
);
  int pos = START_POS;
  // one step per clock while driven; hard stops at both ends
  always @(posedge ref_clk) begin
    if (motor_open && pos < TRAVEL) begin
      pos <= pos + 1;
    end else if (motor_close && pos > 0) begin
      pos <= pos - 1;
    end
  end
  // limits make a few steps early so they can arm before the stop
  assign open_limit_input = (pos >= TRAVEL - 3);
  assign closed_limit_input = (pos <= 3);
  // contacts in series: loop opens at a hard stop or jam
  assign combined_torque_input = !(jam || pos == 0 || pos == TRAVEL);
  // junction tap tells which contact tripped
  assign spare_fault_input = (pos != TRAVEL);
endmodule : vaclt_switch_model

// >>> testbench/vaclt_control_tb.sv
// testbench: command sequences against the switch model
`timescale 1ns/100ps
module vaclt_control_tb;
  import vaclt_pkg::*;
  logic ref_clk, srst, relay_is_fault_output, supply_is_fault_output;
  logic command_word_valid, jam;
  vaclt_mode_t mode;
  logic [15:0] run_limit_ms, actuator_command_word, motor_current_percent_in;
  logic [15:0] actuator_status_word, motor_current_percent;
  logic [1:0] extra_inputs;
  logic open_limit_input, closed_limit_input, spare_fault_input, combined_torque_input;
  logic motor_open, motor_close, spare_relay_output, switched_supply_output;
  logic torque_open_flag, torque_closed_flag;
  int err_count = 0;
  int compares = 0;
  // short tick and windows keep the run small
  vaclt_control #(.TICK_DIVIDE(4), .TORQUE_CLEAR_MS(10), .START_MON_MS(20)) uut (
    .ref_clk, .srst, .mode, .run_limit_ms, .relay_is_fault_output,
    .supply_is_fault_output, .open_limit_input, .closed_limit_input,
    .spare_fault_input, .combined_torque_input, .extra_inputs,
    .actuator_command_word, .command_word_valid, .motor_current_percent_in,
    .actuator_status_word, .motor_current_percent, .motor_open, .motor_close,
    .spare_relay_output, .switched_supply_output, .torque_open_flag, .torque_closed_flag);
  vaclt_switch_model u_sw (.ref_clk, .motor_open, .motor_close, .jam,
    .open_limit_input, .closed_limit_input, .spare_fault_input, .combined_torque_input);
  //----------------------------------------
  // helpers
  //----------------------------------------
  task wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wt
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task cb(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask : cb
  // one word held valid for a single edge
  task cmd(input logic [15:0] w);
    actuator_command_word = w;
    command_word_valid = 1'b1;
    wt(1);
    command_word_valid = 1'b0;
    wt(2);
  endtask : cmd
  // bounded wait; a motor still running at the end counts as a mismatch
  task till_stop;
    for (int i = 0; i < 400; i++) begin
      if (!motor_open && !motor_close) break;
      wt(1);
    end
    cb(motor_open | motor_close, 1'b0);
  endtask : till_stop
  task print_verdict;
    $display("compares=%0d errors=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // watchdog, well beyond the few thousand cycles of the run
  initial begin
    #(25 * 20000);
    err_count++;
    print_verdict();
  end
  //----------------------------------------
  // tests
  //----------------------------------------
  initial begin
    srst = 1'b1;
    mode = VACLT_MODE_BOTH_TORQUE;
    run_limit_ms = 16'h03e8;
    relay_is_fault_output = 1'b0;
    supply_is_fault_output = 1'b0;
    command_word_valid = 1'b0;
    actuator_command_word = 16'h0000;
    motor_current_percent_in = 16'h0123;
    extra_inputs = 2'b10;
    jam = 1'b1;
    wt(8);
    srst = 1'b0;
    wt(3);
    cb(actuator_status_word[VACLT_STS_FAULT], 1'b1);
    cmd(16'h0041);
    cb(motor_close, 1'b0);
    cb(actuator_status_word[VACLT_STS_WARNING], 1'b1);
    jam = 1'b0;
    cmd(16'h0044);
    cb(motor_open, 1'b1);
    wt(96);
    cb(motor_open, 1'b1);
    till_stop;
    cb(torque_open_flag, 1'b1);
    chk({13'h0000, actuator_status_word[2:0]}, 16'h0002);
    cmd(16'h0004);
    cb(motor_open, 1'b0);
    cmd(16'h0001);
    cb(motor_close, 1'b1);
    till_stop;
    cb(torque_closed_flag, 1'b1);
    $display("test power-up and torque stops done");
    cmd(16'h0004);
    wt(70);
    jam = 1'b1;
    wt(60);
    cb(motor_open, 1'b0);
    cb(actuator_status_word[VACLT_STS_FAULT], 1'b1);
    relay_is_fault_output = 1'b1;
    wt(1);
    cb(spare_relay_output, 1'b1);
    relay_is_fault_output = 1'b0;
    cmd(16'h0044);
    cb(motor_open, 1'b0);
    cmd(16'h0041);
    cb(motor_close, 1'b1);
    wt(60);
    cb(motor_close, 1'b0);
    cb(actuator_status_word[VACLT_STS_FAULT], 1'b1);
    jam = 1'b0;
    cmd(16'h0044);
    cb(motor_open, 1'b1);
    till_stop;
    $display("test mid-travel torque done");
    run_limit_ms = 16'h000a;
    cmd(16'h0001);
    wt(60);
    cb(motor_close, 1'b0);
    cb(actuator_status_word[VACLT_STS_FAULT], 1'b1);
    run_limit_ms = 16'h03e8;
    cmd(16'h0041);
    cb(motor_close, 1'b1);
    till_stop;
    $display("test run time done");
    mode = VACLT_MODE_CLOSED_TORQUE;
    cmd(16'h0004);
    till_stop;
    cb(combined_torque_input, 1'b1);
    cmd(16'h0004);
    cb(motor_open, 1'b0);
    cmd(16'h0001);
    till_stop;
    cb(torque_closed_flag, 1'b1);
    $display("test closed-end torque done");
    mode = VACLT_MODE_OPEN_TORQUE;
    cmd(16'h0004);
    wt(70);
    jam = 1'b1;
    wt(60);
    cb(actuator_status_word[VACLT_STS_FAULT], 1'b1);
    jam = 1'b0;
    cmd(16'h0041);
    till_stop;
    cb(combined_torque_input, 1'b1);
    cmd(16'h0001);
    cb(motor_close, 1'b0);
    cmd(16'h0004);
    till_stop;
    cb(torque_open_flag, 1'b1);
    $display("test open-end torque done");
    actuator_command_word = 16'h9000;
    command_word_valid = 1'b1;
    wt(2);
    cb(spare_relay_output, 1'b1);
    cb(switched_supply_output, 1'b1);
    command_word_valid = 1'b0;
    relay_is_fault_output = 1'b1;
    supply_is_fault_output = 1'b1;
    wt(1);
    cb(spare_relay_output, 1'b0);
    cb(switched_supply_output, 1'b0);
    chk(motor_current_percent, 16'h0123);
    chk({14'h0000, actuator_status_word[15:14]}, 16'h0002);
    $display("test outputs and mirrors done");
    print_verdict();
  end
endmodule : vaclt_control_tb
